// ### rtl/pdm_defines.svh
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_PINS             8
`define PDM_ADDR_W           8

`define PDM_OFS_PORT_CFG     8'h00
`define PDM_OFS_INPUT_CFG    8'h04
`define PDM_OFS_FUNC_SEL     8'h08
`define PDM_OFS_OUT          8'h0c
`define PDM_OFS_IN           8'h10
`define PDM_OFS_EDGE_CFG     8'h14
`define PDM_OFS_INTR_STAT    8'h18
`define PDM_OFS_INTR_MASK    8'h1c
`define PDM_OFS_FREEZE       8'h20

`define PDM_CFG_FIELD_W      4
`define PDM_CFG_MODE_LSB     0
`define PDM_CFG_IN_EN_BIT    3
`define PDM_SEL_FIELD_W      2
`define PDM_EDGE_FIELD_W     2
`define PDM_OUT_EN_LSB       8

`define PDM_MODE_HIZ         3'h0
`define PDM_MODE_RSVD        3'h1
`define PDM_MODE_PULL_UP     3'h2
`define PDM_MODE_PULL_DN     3'h3
`define PDM_MODE_OD_LOW      3'h4
`define PDM_MODE_OD_HIGH     3'h5
`define PDM_MODE_STRONG      3'h6
`define PDM_MODE_PULL_BOTH   3'h7

`define PDM_SEL_REG          2'h0
`define PDM_SEL_AMUX_A       2'h1
`define PDM_SEL_AMUX_B       2'h2
`define PDM_SEL_PERIPH       2'h3

`define PDM_EDGE_RISE_BIT    0
`define PDM_EDGE_FALL_BIT    1

`define PDM_RST_PORT_CFG     32'h0000_0000
`define PDM_RST_BYTE         8'h00
`define PDM_RST_HALF         16'h0000

`endif

// ### rtl/pdm_drive_resolve.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_drive_resolve
(
  input  wire logic          [2:0] mode,
  input  wire logic                periph,
  input  wire logic                out_val,
  input  wire logic                out_en,
  output pdm_pkg::pdm_drive_type   drive
);

  always_comb
  begin
    drive       = '0;
    drive.value = out_val;
    if (mode == `PDM_MODE_HIZ)
    begin
      drive = '0; // [RULE7]
    end
    else if (periph)
    begin
      if (out_en)
      begin
        drive.strong_en = 1'b1; // [RULE14]
      end
      else
      begin
        unique case (mode)
          `PDM_MODE_RSVD:
          begin
            drive.pull_up   = 1'b1; // [RULE8]
            drive.pull_down = 1'b1;
          end
          `PDM_MODE_PULL_UP:   drive.pull_up = 1'b1; // [RULE14]
          `PDM_MODE_PULL_DN:   drive.pull_down = 1'b1; // [RULE14]
          `PDM_MODE_PULL_BOTH:
          begin
            drive.pull_up   = out_val; // [RULE14]
            drive.pull_down = ~out_val;
          end
          default:             drive.strong_en = 1'b0;
        endcase
      end
    end
    else if (out_en) // Otherwise floating [RULE9]
    begin
      unique case (mode)
        `PDM_MODE_RSVD:      drive.strong_en = 1'b1; // [RULE8]
        `PDM_MODE_PULL_UP:
        begin
          drive.strong_en = ~out_val; // [RULE10]
          drive.pull_up   = out_val;
        end
        `PDM_MODE_PULL_DN:
        begin
          drive.strong_en = out_val; // [RULE10]
          drive.pull_down = ~out_val;
        end
        `PDM_MODE_OD_LOW:    drive.strong_en = ~out_val; // [RULE11]
        `PDM_MODE_OD_HIGH:   drive.strong_en = out_val; // [RULE12]
        `PDM_MODE_STRONG:    drive.strong_en = 1'b1; // [RULE10]
        `PDM_MODE_PULL_BOTH:
        begin
          drive.pull_up   = out_val; // [RULE13]
          drive.pull_down = ~out_val;
        end
        default:             drive.strong_en = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/pdm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_pin_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_raw,
  input  wire logic in_en,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  pdm_pkg::pdm_sync_state_type state_reg;
  pdm_pkg::pdm_sync_state_type state_next;

  always_comb
  begin
    state_next     = state_reg;
    state_next.ff1 = pin_raw;
    state_next.ff2 = state_reg.ff1;
    state_next.ff3 = state_reg.ff2;
    // Change taken only once the second and third stages agree
    if (state_reg.ff2 == state_reg.ff3)
    begin
      state_next.stable = state_reg.ff3;
    end
    // Disabled buffer reads low [RULE2]
    state_next.lvl = state_next.stable & in_en;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Enabling the buffer on a high pin counts as a rising edge
  assign level = state_reg.lvl;
  assign rise  = state_next.lvl & ~state_reg.lvl;
  assign fall  = ~state_next.lvl & state_reg.lvl;

endmodule
`default_nettype wire

// ### rtl/pdm_pkg.sv
`default_nettype none
package pdm_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pdm_bus_req_type;

  typedef struct packed {
    logic strong_en;
    logic value;
    logic pull_up;
    logic pull_down;
  } pdm_drive_type;

  typedef struct packed {
    logic [7:0] strong_en;
    logic [7:0] value;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } pdm_port_drive_type;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic stable;
    logic lvl;
  } pdm_sync_state_type;

  typedef struct packed {
    logic [31:0]        port_cfg;
    logic [7:0]         in_thr;
    logic [15:0]        func_sel;
    logic [7:0]         out_val;
    logic [7:0]         out_en;
    logic [15:0]        edge_cfg;
    logic [7:0]         intr_stat;
    logic [7:0]         intr_mask;
    logic               freeze;
    logic [31:0]        rdata;
    pdm_port_drive_type drive;
    logic [7:0]         periph_in;
    logic [7:0]         amux_a;
    logic [7:0]         amux_b;
    logic               irq;
  } pdm_state_type;

endpackage
`default_nettype wire

// ### rtl/pdm_port.sv
// Behaviour
// RULE1 - A port has eight pins, every per-pin field repeated per pin.
// RULE2 - Each pin's input buffer has its own enable bit in the port config.
// RULE3 - Sampled input goes to the input register and to the selected peripheral.
// RULE4 - Software keeps the input buffer off on analog-only pins.
// RULE5 - Per-pin bit selects CMOS/I2C or TTL input threshold.
// RULE6 - Per-pin function select picks register or peripheral output control.
// RULE7 - Eight drive modes per pin; mode 0 is always high impedance.
// RULE8 - Mode 1 reserved: strong under register, weak both ways peripheral disabled.
// RULE9 - Register or analog bus control with enable clear floats the pin.
// RULE10 - Register control: mode 2 weak high, mode 3 weak low, mode 6 strong.
// RULE11 - Mode 4 register control: strong low for 0, float for 1.
// RULE12 - Mode 5 register control: strong high for 1, float for 0.
// RULE13 - Mode 7 register control: weak high for 1, weak low for 0.
// RULE14 - Peripheral control: enabled drives strong; disabled uses mode-dependent pulls.
// RULE15 - Each pin raises an interrupt on rising, falling or both edges.
// RULE16 - Frozen mode holds every pin's previous output state.
// RULE17 - After reset every pin is high impedance with input buffer off.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_port
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire pdm_pkg::pdm_bus_req_type  bus_req,
  output logic                    [31:0] bus_rdata,
  input  wire logic                [7:0] pin_in,
  output pdm_pkg::pdm_port_drive_type    pin_drive,
  output logic                     [7:0] input_buf_en,
  output logic                     [7:0] input_threshold_select,
  output logic                     [7:0] analog_mux_bus_a,
  output logic                     [7:0] analog_mux_bus_b,
  input  wire logic                [7:0] periph_out,
  input  wire logic                [7:0] periph_out_en,
  output logic                     [7:0] periph_in,
  output logic                           irq
);

  pdm_pkg::pdm_state_type     state_reg;
  pdm_pkg::pdm_state_type     state_next;
  pdm_pkg::pdm_port_drive_type drive_res;
  logic [7:0]                 in_level;
  logic [7:0]                 in_rise;
  logic [7:0]                 in_fall;
  logic [7:0]                 sel_periph;
  logic [7:0]                 sel_amux_a;
  logic [7:0]                 sel_amux_b;
  logic [7:0]                 in_en_bits;

  genvar g;
  generate
    for (g = 0; g < `PDM_PINS; g = g + 1) // [RULE1]
    begin : pin
      logic [1:0]            sel;
      logic                  src_out;
      logic                  src_oe;
      pdm_pkg::pdm_drive_type drv;

      assign sel = state_reg.func_sel[g*`PDM_SEL_FIELD_W +: `PDM_SEL_FIELD_W];
      assign sel_periph[g] = (sel == `PDM_SEL_PERIPH); // [RULE6]
      assign sel_amux_a[g] = (sel == `PDM_SEL_AMUX_A);
      assign sel_amux_b[g] = (sel == `PDM_SEL_AMUX_B);
      assign in_en_bits[g] =
        state_reg.port_cfg[g*`PDM_CFG_FIELD_W + `PDM_CFG_IN_EN_BIT]; // [RULE2]
      // Analog bus selections keep the register as output source [RULE9]
      assign src_out = sel_periph[g] ? periph_out[g] : state_reg.out_val[g]; // [RULE6]
      assign src_oe  = sel_periph[g] ? periph_out_en[g] : state_reg.out_en[g];

      pdm_pin_sync u_sync
      (
        .clk     (clk),
        .rst     (rst),
        .pin_raw (pin_in[g]),
        .in_en   (in_en_bits[g]),
        .level   (in_level[g]),
        .rise    (in_rise[g]),
        .fall    (in_fall[g])
      );

      pdm_drive_resolve u_drive
      (
        .mode    (state_reg.port_cfg[g*`PDM_CFG_FIELD_W + `PDM_CFG_MODE_LSB +: 3]), // [RULE7]
        .periph  (sel_periph[g]),
        .out_val (src_out),
        .out_en  (src_oe),
        .drive   (drv)
      );

      assign drive_res.strong_en[g] = drv.strong_en;
      assign drive_res.value[g]     = drv.value;
      assign drive_res.pull_up[g]   = drv.pull_up;
      assign drive_res.pull_down[g] = drv.pull_down;
    end
  endgenerate

  always_comb
  begin
    logic [7:0] events;
    logic       stat_rd;
    events  = '0;
    stat_rd = 1'b0;
    state_next = state_reg;

    // Edge events [RULE15]
    for (int i = 0; i < `PDM_PINS; i++)
    begin
      events[i] =
        (in_rise[i] & state_reg.edge_cfg[i*`PDM_EDGE_FIELD_W + `PDM_EDGE_RISE_BIT]) |
        (in_fall[i] & state_reg.edge_cfg[i*`PDM_EDGE_FIELD_W + `PDM_EDGE_FALL_BIT]);
    end

    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        `PDM_OFS_PORT_CFG:  state_next.port_cfg = bus_req.wdata; // [RULE2]
        `PDM_OFS_INPUT_CFG: state_next.in_thr = bus_req.wdata[7:0]; // [RULE5]
        `PDM_OFS_FUNC_SEL:  state_next.func_sel = bus_req.wdata[15:0]; // [RULE6]
        `PDM_OFS_OUT:
        begin
          state_next.out_val = bus_req.wdata[7:0];
          state_next.out_en  = bus_req.wdata[`PDM_OUT_EN_LSB +: 8];
        end
        `PDM_OFS_EDGE_CFG:  state_next.edge_cfg = bus_req.wdata[15:0]; // [RULE15]
        `PDM_OFS_INTR_MASK: state_next.intr_mask = bus_req.wdata[7:0];
        `PDM_OFS_FREEZE:    state_next.freeze = bus_req.wdata[0]; // [RULE16]
        default:            state_next.freeze = state_reg.freeze;
      endcase
    end

    state_next.rdata = '0;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `PDM_OFS_PORT_CFG:  state_next.rdata = state_reg.port_cfg;
        `PDM_OFS_INPUT_CFG: state_next.rdata = {24'h00_0000, state_reg.in_thr};
        `PDM_OFS_FUNC_SEL:  state_next.rdata = {16'h0000, state_reg.func_sel};
        `PDM_OFS_OUT:       state_next.rdata = {16'h0000, state_reg.out_en, state_reg.out_val};
        `PDM_OFS_IN:        state_next.rdata = {24'h00_0000, in_level}; // [RULE3]
        `PDM_OFS_EDGE_CFG:  state_next.rdata = {16'h0000, state_reg.edge_cfg};
        `PDM_OFS_INTR_STAT:
        begin
          state_next.rdata = {24'h00_0000, state_reg.intr_stat};
          stat_rd          = 1'b1;
        end
        `PDM_OFS_INTR_MASK: state_next.rdata = {24'h00_0000, state_reg.intr_mask};
        `PDM_OFS_FREEZE:    state_next.rdata = {31'h0000_0000, state_reg.freeze};
        default:            state_next.rdata = '0;
      endcase
    end

    // An event in the clearing cycle survives the read
    state_next.intr_stat = (stat_rd ? `PDM_RST_BYTE : state_reg.intr_stat) | events; // [RULE15]
    state_next.irq       = |(state_next.intr_stat & state_next.intr_mask);

    // Peripheral sees input only when it owns the pin [RULE3]
    state_next.periph_in = in_level & sel_periph;

    // Frozen pins keep their last drive and analog hookup [RULE16]
    if (!state_reg.freeze)
    begin
      state_next.drive  = drive_res;
      state_next.amux_a = sel_amux_a;
      state_next.amux_b = sel_amux_b;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg           <= '0;
      state_reg.port_cfg  <= `PDM_RST_PORT_CFG; // [RULE17]
      state_reg.in_thr    <= `PDM_RST_BYTE;
      state_reg.func_sel  <= `PDM_RST_HALF;
      state_reg.edge_cfg  <= `PDM_RST_HALF;
      state_reg.intr_mask <= `PDM_RST_BYTE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata              = state_reg.rdata;
  assign pin_drive              = state_reg.drive;
  assign input_buf_en           = in_en_bits;
  assign input_threshold_select = state_reg.in_thr; // [RULE5]
  assign analog_mux_bus_a       = state_reg.amux_a;
  assign analog_mux_bus_b       = state_reg.amux_b;
  assign periph_in              = state_reg.periph_in;
  assign irq                    = state_reg.irq;

endmodule
`default_nettype wire

// ### tb/pdm_board.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_board
(
  input  wire logic                        clk,
  input  wire pdm_pkg::pdm_port_drive_type drive,
  input  wire logic                  [7:0] ext_en,
  input  wire logic                  [7:0] ext_val,
  output logic                       [7:0] pin
);
  // A floating pin wanders so that a missing drive never reads as a lucky match
  logic [7:0] flt_reg = 8'h55;
  always @(posedge clk) flt_reg <= ~flt_reg;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (drive.strong_en[i]) pin[i] = drive.value[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (drive.pull_up[i] != drive.pull_down[i]) pin[i] = drive.pull_up[i];
      else pin[i] = flt_reg[i];
    end
  end
endmodule
`default_nettype wire

// ### tb/pdm_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_port_sva
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire pdm_pkg::pdm_bus_req_type    bus_req,
  input wire logic                 [31:0] bus_rdata,
  input wire logic                  [7:0] pin_in,
  input wire pdm_pkg::pdm_port_drive_type pin_drive,
  input wire logic                  [7:0] input_buf_en,
  input wire logic                  [7:0] input_threshold_select,
  input wire logic                  [7:0] analog_mux_bus_a,
  input wire logic                  [7:0] analog_mux_bus_b,
  input wire logic                  [7:0] periph_out,
  input wire logic                  [7:0] periph_out_en,
  input wire logic                  [7:0] periph_in,
  input wire logic                        irq
);
  // Pin 0 shadow only: the other pins share the same field layout
  logic [2:0] mode_reg;
  logic [1:0] sel_reg;
  logic       oe_reg;
  logic       val_reg;
  logic       frz_reg;
  logic [2:0] d0;
  logic [7:0] en_w;
  logic [7:0] a;
  logic [31:0] d;
  assign a = bus_req.addr;
  assign d = bus_req.wdata;
  assign d0 = {pin_drive.strong_en[0], pin_drive.pull_up[0], pin_drive.pull_down[0]};
  assign en_w = {d[31], d[27], d[23], d[19], d[15], d[11], d[7], d[3]};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {mode_reg, sel_reg, oe_reg, val_reg, frz_reg} <= 8'h00;
    end
    else if (bus_req.wr)
    begin
      if (a == 8'h00) mode_reg <= d[2:0];
      if (a == 8'h08) sel_reg <= d[1:0];
      if (a == 8'h0c) {oe_reg, val_reg} <= {d[8], d[0]};
      if (a == 8'h20) frz_reg <= d[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    bus_req.wr && a == 8'h00;
  endsequence
  sequence s_live_reg;
    !frz_reg && sel_reg != 2'h3;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> pin_drive == 32'h0 && input_buf_en == 8'h00 && !irq)
    else $error("outputs not quiet after reset");
  a_buf_en_bit: assert property (s_cfg_wr |=> input_buf_en == $past(en_w))
    else $error("input buffer enable mismatch");
  a_thr_select: assert property (bus_req.wr && a == 8'h04 |=> input_threshold_select == $past(d[7:0]))
    else $error("threshold select mismatch");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_mode0_hiz: assert property (!frz_reg && mode_reg == 3'h0 |=> d0 == 3'h0)
    else $error("mode 0 pin not floating");
  a_oe_off_hiz: assert property (s_live_reg ##0 !oe_reg |=> d0 == 3'h0)
    else $error("disabled output not floating");
  a_od_low: assert property (s_live_reg ##0 oe_reg && mode_reg == 3'h4 && sel_reg == 2'h0
    |=> ($past(val_reg) ? d0 == 3'h0 : d0 == 3'h4 && !pin_drive.value[0]))
    else $error("open drain low drive wrong");
  a_periph_strong: assert property (!frz_reg && sel_reg == 2'h3 && mode_reg != 3'h0 && periph_out_en[0]
    |=> d0 == 3'h4 && pin_drive.value[0] == $past(periph_out[0]))
    else $error("peripheral drive not strong");
  a_freeze_hold: assert property (frz_reg ##1 frz_reg |-> $stable(pin_drive) && $stable(analog_mux_bus_a))
    else $error("frozen outputs moved");
  a_periph_gate: assert property (sel_reg != 2'h3 |=> !periph_in[0])
    else $error("peripheral input not gated");
  a_amux_route: assert property (!frz_reg && sel_reg == 2'h1 |=> analog_mux_bus_a[0] && !analog_mux_bus_b[0])
    else $error("analog bus A not connected");
endmodule
`default_nettype wire

// ### tb/test_pin_drive_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_pin_drive_mode_control;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  pdm_pkg::pdm_bus_req_type   bus_req = '0;
  pdm_pkg::pdm_port_drive_type drv;
  logic                [31:0] rdata;
  logic                 [7:0] pin, ibe, thr, ama, amb, pi, po, po_en, ext_en, ext_val;
  logic                       irq;
  int                         err_count = 0;
  int                         tests_run = 0;
  initial po = 8'h00;
  initial po_en = 8'h00;
  initial ext_en = 8'h00;
  initial ext_val = 8'h00;
  always #20 clk = ~clk;
  pdm_port u_pdm_port (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(rdata), .pin_in(pin),
    .pin_drive(drv), .input_buf_en(ibe), .input_threshold_select(thr), .analog_mux_bus_a(ama),
    .analog_mux_bus_b(amb), .periph_out(po), .periph_out_en(po_en), .periph_in(pi), .irq(irq));
  pdm_board u_pdm_board (.clk(clk), .drive(drv), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    chk(nm, e, rdata);
    @(posedge clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [2:0] exp_drv(input logic [1:0] s, input logic [2:0] m,
                                         input logic e, input logic v);
    if (m == 3'h0) return 3'h0;
    if (s != 2'h3)
    begin
      if (!e) return 3'h0;
      case (m)
        3'h2: return v ? 3'h2 : 3'h4;
        3'h3: return v ? 3'h4 : 3'h1;
        3'h4: return v ? 3'h0 : 3'h4;
        3'h5: return v ? 3'h4 : 3'h0;
        3'h7: return v ? 3'h2 : 3'h1;
        default: return 3'h4;
      endcase
    end
    if (e) return 3'h4;
    case (m)
      3'h1: return 3'h3;
      3'h2: return 3'h2;
      3'h3: return 3'h1;
      3'h7: return v ? 3'h2 : 3'h1;
      default: return 3'h0;
    endcase
  endfunction
  task automatic t_reset();
    settle(0);
    chk("drive", 32'h0, drv);
    chk("buf_en", 32'h0, 32'(ibe));
    @(posedge clk);
    rd(8'h00, 32'h0, "cfg");
  endtask
  task automatic t_regs();
    wr(8'h04, 32'h0000_00a5);
    wr(8'h00, 32'h8000_0008);
    settle(0);
    chk("thr", 32'ha5, 32'(thr));
    chk("buf_en", 32'h81, 32'(ibe));
    @(posedge clk);
    rd(8'h04, 32'ha5, "in_cfg");
    rd(8'h40, 32'h0, "unmapped");
  endtask
  task automatic t_modes();
    logic [2:0] x;
    logic       ie;
    for (int s = 0; s < 4; s++)
      for (int m = 0; m < 8; m++)
        for (int k = 0; k < 4; k++)
        begin
          ie = (s == 0 || s == 3);
          wr(8'h08, {16'h0, {8{s[1:0]}}});
          wr(8'h00, {8{ie, m[2:0]}});
          wr(8'h0c, {16'h0, {8{k[1]}}, {8{k[0]}}});
          po_en <= {8{k[1]}};
          po <= {8{k[0]}};
          settle(2);
          x = exp_drv(s[1:0], m[2:0], k[1], k[0]);
          chk("strong", {24'h0, {8{x[2]}}}, 32'(drv.strong_en));
          chk("pull_up", {24'h0, {8{x[1]}}}, 32'(drv.pull_up));
          chk("pull_dn", {24'h0, {8{x[0]}}}, 32'(drv.pull_down));
          if (x[2]) chk("value", {24'h0, {8{k[0]}}}, 32'(drv.value));
          chk("amux_a", {24'h0, {8{s == 1}}}, 32'(ama));
          chk("amux_b", {24'h0, {8{s == 2}}}, 32'(amb));
          @(posedge clk);
          if (x[2] && ie)
          begin
            settle(6);
            chk("periph_in", {24'h0, {8{k[0] && s == 3}}}, 32'(pi));
            @(posedge clk);
            rd(8'h10, {24'h0, {8{k[0]}}}, "in_reg");
          end
        end
  endtask
  task automatic t_irq();
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h8888_8888);
    // Pins settle before edges are armed, so the earlier fall leaves no status
    settle(8);
    @(posedge clk);
    wr(8'h14, 32'h0000_0039);
    rd(8'h18, 32'h0, "stat_idle");
    wr(8'h1c, 32'h07);
    ext_val <= 8'hff;
    settle(8);
    chk("irq", 32'h1, 32'(irq));
    @(posedge clk);
    rd(8'h18, 32'h05, "stat_rise");
    settle(2);
    chk("irq_clr", 32'h0, 32'(irq));
    @(posedge clk);
    ext_val <= 8'h00;
    settle(8);
    @(posedge clk);
    rd(8'h18, 32'h06, "stat_fall");
    wr(8'h1c, 32'h0);
    ext_val <= 8'hff;
    settle(8);
    chk("irq_mask", 32'h0, 32'(irq));
    @(posedge clk);
    rd(8'h18, 32'h05, "stat_masked");
    ext_en <= 8'h00;
  endtask
  task automatic t_freeze();
    wr(8'h00, 32'h6666_6666);
    wr(8'h0c, 32'h0000_ffff);
    wr(8'h20, 32'h1);
    wr(8'h0c, 32'h0000_ff00);
    settle(3);
    chk("frozen", 32'hff, 32'(drv.value));
    @(posedge clk);
    wr(8'h20, 32'h0);
    settle(2);
    chk("thawed", 32'h0, 32'(drv.value));
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_modes();
    t_irq();
    t_freeze();
    stop_test();
  end
  initial
  begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end
endmodule
bind pdm_port pdm_port_sva u_pdm_port_sva (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_drive(pin_drive), .input_buf_en(input_buf_en),
  .input_threshold_select(input_threshold_select), .analog_mux_bus_a(analog_mux_bus_a),
  .analog_mux_bus_b(analog_mux_bus_b), .periph_out(periph_out), .periph_out_en(periph_out_en),
  .periph_in(periph_in), .irq(irq));
`default_nettype wire
